// ===== rtl/mst_pkg.sv
// Purpose: constants for the measurement statistics tracker
// Assumes: one 32-bit word per register, byte addresses
// Notes: samples are unsigned, channel 0 current, 1 voltage, 2 power
package mst_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] MST_OFS_CTRL = 8'h00;
  localparam logic [7:0] MST_OFS_CMD = 8'h04;
  localparam logic [7:0] MST_OFS_DUR0 = 8'h08;
  localparam logic [7:0] MST_OFS_MIN0 = 8'h14;
  localparam logic [7:0] MST_OFS_AVG0 = 8'h2c;
  localparam logic [7:0] MST_OFS_PEAK0 = 8'h38;
  localparam logic [7:0] MST_OFS_STAT = 8'h44;
  localparam logic [7:0] MST_STEP = 8'h04;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int MST_CTRL_SLIDE0 = 0;
  localparam int MST_CTRL_EDGE0 = 3;
  localparam int MST_CMD_CLR_MIN = 0;
  localparam int MST_CMD_CLR_MAX = 1;
  localparam int MST_CMD_CLR_AVG0 = 2;
  localparam int MST_TRG_MIN = 0;
  localparam int MST_TRG_MAX = 1;
  localparam int MST_TRG_PER0 = 2;
  localparam int MST_TRG_CLR0 = 5;
  localparam int MST_NTRG = 8;
  localparam int MST_NCH = 3;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [5:0] MST_CTRL_RST = 6'h00;
  localparam logic [15:0] MST_DUR_RST = 16'h0010;
endpackage

// ===== rtl/mst_avg_if.sv
// Purpose: link between the top and one average channel
// Assumes: single clock domain
// Notes: ctl drives settings and samples, chan returns results
`timescale 1ns/1ps
interface mst_avg_if #(
  parameter int W = 16,
  parameter int CNT_W = 16
);
  logic sample_valid;
  logic [W-1:0] sample;
  logic clear;
  logic period_edge;
  logic sliding;
  logic by_edge;
  logic [CNT_W-1:0] duration;
  logic [W-1:0] avg;
  logic [W-1:0] peak;
  modport ctl (
    output sample_valid, sample, clear, period_edge, sliding, by_edge,
    output duration,
    input avg, peak
  );
  modport chan (
    input sample_valid, sample, clear, period_edge, sliding, by_edge,
    input duration,
    output avg, peak
  );
endinterface

// ===== rtl/mst_minmax.sv
// Purpose: running minimum and maximum of one quantity
// Assumes: clears are one-cycle pulses from the top
// Notes: value reads zero until the first sample after a clear
`timescale 1ns/1ps
module mst_minmax #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // samples and clears
  input wire logic sample_valid,
  input wire logic [W-1:0] sample,
  input wire logic clr_min,
  input wire logic clr_max,
  // results
  output logic [W-1:0] min_val,
  output logic [W-1:0] max_val,
  output logic min_ok,
  output logic max_ok
);
  logic [W-1:0] min_reg, min_next, max_reg, max_next;
  logic min_ok_reg, min_ok_next, max_ok_reg, max_ok_next;

  always_comb begin
    min_next = min_reg;
    max_next = max_reg;
    min_ok_next = min_ok_reg;
    max_ok_next = max_ok_reg;
    if (clr_min) begin
      min_ok_next = 1'b0;
      min_next = '0;
    end
    if (clr_max) begin
      max_ok_next = 1'b0;
      max_next = '0;
    end
    // a sample in the clear cycle seeds the fresh value
    if (sample_valid) begin
      if (!min_ok_next || sample < min_reg) begin
        min_next = sample;
      end
      if (!max_ok_next || sample > max_reg) begin
        max_next = sample;
      end
      min_ok_next = 1'b1;
      max_ok_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      min_reg <= '0;
      max_reg <= '0;
      min_ok_reg <= 1'b0;
      max_ok_reg <= 1'b0;
    end else begin
      min_reg <= min_next;
      max_reg <= max_next;
      min_ok_reg <= min_ok_next;
      max_ok_reg <= max_ok_next;
    end
  end

  assign min_val = min_reg;
  assign max_val = max_reg;
  assign min_ok = min_ok_reg;
  assign max_ok = max_ok_reg;
endmodule

// ===== rtl/mst_avg_chan.sv
// Purpose: one demand or average channel with optional peak
// Assumes: samples arrive no faster than one per W+CNT_W+1 cycles
// Notes: a result due while the divider is busy is dropped
`timescale 1ns/1ps
module mst_avg_chan #(
  parameter int W = 16,
  parameter int DEPTH = 64,
  parameter int CNT_W = 16,
  parameter bit HAS_PEAK = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // channel link
  mst_avg_if.chan ch
);
  localparam int SW = W + CNT_W;
  localparam int AW = $clog2(DEPTH);
  localparam int BW = $clog2(SW + 1);
  localparam logic [CNT_W-1:0] LEN_MAX = CNT_W'(DEPTH);
  localparam logic [BW-1:0] BITS_ALL = BW'(SW);

  typedef enum logic [1:0] {
    MST_DIV_IDLE = 2'b01,
    MST_DIV_RUN = 2'b10
  } mst_div_t;

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_idx;
  logic [CNT_W-1:0] fill_reg, fill_next, cnt_reg, cnt_next, len;
  logic [SW-1:0] sum_reg, sum_next, samp_x, old_x;
  logic [SW-1:0] rem_reg, rem_next, quo_reg, quo_next, trial, num;
  logic [CNT_W-1:0] den_reg, den_next, lden;
  logic [BW-1:0] bits_reg, bits_next;
  logic [W-1:0] avg_reg, avg_next, peak_reg, peak_next;
  mst_div_t st_reg, st_next;
  logic launch, mem_we;

  // zero length would end a period on every sample with a zero divisor
  function automatic logic [CNT_W-1:0] eff_len(
    input logic [CNT_W-1:0] d,
    input logic slide
  );
    logic [CNT_W-1:0] r;
    r = (d == '0) ? CNT_W'(1) : d;
    if (slide && r > LEN_MAX) begin
      r = LEN_MAX;
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // accumulation and divider
  // ------------------------------------------------------------
  always_comb begin
    len = eff_len(ch.duration, ch.sliding);
    rd_idx = wr_reg - len[AW-1:0];
    samp_x = {{CNT_W{1'b0}}, ch.sample};
    old_x = {{CNT_W{1'b0}}, mem[rd_idx]};
    wr_next = wr_reg;
    fill_next = fill_reg;
    cnt_next = cnt_reg;
    sum_next = sum_reg;
    rem_next = rem_reg;
    quo_next = quo_reg;
    den_next = den_reg;
    bits_next = bits_reg;
    avg_next = avg_reg;
    peak_next = peak_reg;
    st_next = st_reg;
    launch = 1'b0;
    num = '0;
    lden = len;
    mem_we = 1'b0;
    trial = {rem_reg[SW-2:0], quo_reg[SW-1]};
    if (ch.by_edge) begin
      if (ch.period_edge) begin
        launch = (cnt_reg != '0);
        num = sum_reg;
        lden = cnt_reg;
        sum_next = ch.sample_valid ? samp_x : '0;
        cnt_next = ch.sample_valid ? CNT_W'(1) : '0;
      end else if (ch.sample_valid && cnt_reg != '1) begin
        sum_next = sum_reg + samp_x;
        cnt_next = cnt_reg + CNT_W'(1);
      end
    end else if (ch.sample_valid && ch.sliding) begin
      mem_we = 1'b1;
      wr_next = wr_reg + AW'(1);
      if (fill_reg >= len) begin
        sum_next = sum_reg + samp_x - old_x;
      end else begin
        sum_next = sum_reg + samp_x;
        fill_next = fill_reg + CNT_W'(1);
      end
      launch = (fill_next >= len);
      num = sum_next;
    end else if (ch.sample_valid) begin
      if (cnt_reg + CNT_W'(1) >= len) begin
        launch = 1'b1;
        num = sum_reg + samp_x;
        sum_next = '0;
        cnt_next = '0;
      end else begin
        sum_next = sum_reg + samp_x;
        cnt_next = cnt_reg + CNT_W'(1);
      end
    end
    case (st_reg)
      MST_DIV_IDLE: begin
        if (launch) begin
          rem_next = '0;
          quo_next = num;
          den_next = lden;
          bits_next = BITS_ALL;
          st_next = MST_DIV_RUN;
        end
      end
      MST_DIV_RUN: begin
        if (trial >= {{W{1'b0}}, den_reg}) begin
          rem_next = trial - {{W{1'b0}}, den_reg};
          quo_next = {quo_reg[SW-2:0], 1'b1};
        end else begin
          rem_next = trial;
          quo_next = {quo_reg[SW-2:0], 1'b0};
        end
        bits_next = bits_reg - BW'(1);
        if (bits_reg == BW'(1)) begin
          st_next = MST_DIV_IDLE;
          avg_next = quo_next[W-1:0];
          if (HAS_PEAK && quo_next[W-1:0] > peak_reg) begin
            peak_next = quo_next[W-1:0];
          end
        end
      end
      default: begin
        st_next = MST_DIV_IDLE;
      end
    endcase
    if (ch.clear) begin
      wr_next = '0;
      fill_next = '0;
      cnt_next = '0;
      sum_next = '0;
      avg_next = '0;
      peak_next = '0;
      st_next = MST_DIV_IDLE;
      mem_we = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_reg <= '0;
      fill_reg <= '0;
      cnt_reg <= '0;
      sum_reg <= '0;
      rem_reg <= '0;
      quo_reg <= '0;
      den_reg <= '0;
      bits_reg <= '0;
      avg_reg <= '0;
      peak_reg <= '0;
      st_reg <= MST_DIV_IDLE;
    end else begin
      wr_reg <= wr_next;
      fill_reg <= fill_next;
      cnt_reg <= cnt_next;
      sum_reg <= sum_next;
      rem_reg <= rem_next;
      quo_reg <= quo_next;
      den_reg <= den_next;
      bits_reg <= bits_next;
      avg_reg <= avg_next;
      peak_reg <= peak_next;
      st_reg <= st_next;
    end
  end

  // window store, stale slots are masked by the fill count
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem[wr_reg] <= ch.sample;
    end
  end

  assign ch.avg = avg_reg;
  assign ch.peak = peak_reg;
endmodule

// ===== rtl/mst_top.sv
// Purpose: statistics tracker top with register port and triggers
// Assumes: triggers are asynchronous pins, samples are core_clk logic
// Notes: W must stay below 32 for the read data layout
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module mst_top #(
  parameter int W = 16,
  parameter int DEPTH = 64,
  parameter int CNT_W = 16,
  parameter bit HAS_CURRENT_AVG = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // measurement samples
  input wire logic meas_valid,
  input wire logic [W-1:0] meas_current,
  input wire logic [W-1:0] meas_voltage,
  input wire logic [W-1:0] meas_power,
  // trigger inputs
  input wire logic min_clear_trigger,
  input wire logic max_clear_trigger,
  input wire logic current_avg_period_trigger,
  input wire logic voltage_avg_period_trigger,
  input wire logic power_avg_period_trigger,
  input wire logic current_avg_clear_trigger,
  input wire logic voltage_avg_clear_trigger,
  input wire logic power_avg_clear_trigger
);
  localparam int NT = mst_pkg::MST_NTRG;
  localparam int NC = mst_pkg::MST_NCH;

  logic [NT-1:0] trg_raw, trg_s1, trg_s2, trg_prev, trg_rise;
  logic [5:0] ctrl_reg, ctrl_next;
  logic [CNT_W-1:0] dur_reg [NC];
  logic [CNT_W-1:0] dur_next [NC];
  logic [31:0] rdata_reg, rdata_next;
  logic [W-1:0] samp [NC];
  logic [W-1:0] min_v [NC];
  logic [W-1:0] max_v [NC];
  logic [W-1:0] avg_v [NC];
  logic [W-1:0] peak_v [NC];
  logic [NC-1:0] min_ok, max_ok, cfg_wr_ch;
  logic wr_ctrl, wr_cmd, cfg_wr, clr_min, clr_max;

  // word-aligned decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  function automatic logic [31:0] zx(input logic [W-1:0] v);
    return {{(32-W){1'b0}}, v};
  endfunction

  assign trg_raw = {power_avg_clear_trigger, voltage_avg_clear_trigger,
                    current_avg_clear_trigger, power_avg_period_trigger,
                    voltage_avg_period_trigger, current_avg_period_trigger,
                    max_clear_trigger, min_clear_trigger};
  assign samp[0] = meas_current;
  assign samp[1] = meas_voltage;
  assign samp[2] = meas_power;

  // ------------------------------------------------------------
  // trigger synchronisers
  // ------------------------------------------------------------
  // two stages then edge compare
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      trg_s1 <= '0;
      trg_s2 <= '0;
      trg_prev <= '0;
    end else begin
      trg_s1 <= trg_raw;
      trg_s2 <= trg_s1;
      trg_prev <= trg_s2;
    end
  end
  assign trg_rise = trg_s2 & ~trg_prev;

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  assign wr_ctrl = reg_wr && hit(reg_addr, mst_pkg::MST_OFS_CTRL);
  assign wr_cmd = reg_wr && hit(reg_addr, mst_pkg::MST_OFS_CMD);
  assign cfg_wr = wr_ctrl || (|cfg_wr_ch);

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = reg_wdata[5:0];
    end
    for (int i = 0; i < NC; i++) begin
      cfg_wr_ch[i] = reg_wr && hit(reg_addr,
        mst_pkg::MST_OFS_DUR0 + 8'(i) * mst_pkg::MST_STEP);
      dur_next[i] = cfg_wr_ch[i] ? reg_wdata[CNT_W-1:0] : dur_reg[i];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= mst_pkg::MST_CTRL_RST;
      for (int i = 0; i < NC; i++) begin
        dur_reg[i] <= CNT_W'(mst_pkg::MST_DUR_RST);
      end
    end else begin
      ctrl_reg <= ctrl_next;
      for (int i = 0; i < NC; i++) begin
        dur_reg[i] <= dur_next[i];
      end
    end
  end

  // unmapped and write-only words read zero
  always_comb begin
    rdata_next = '0;
    if (reg_rd) begin
      if (hit(reg_addr, mst_pkg::MST_OFS_CTRL)) begin
        rdata_next = {26'h0, ctrl_reg};
      end
      if (hit(reg_addr, mst_pkg::MST_OFS_STAT)) begin
        rdata_next = {26'h0, max_ok, min_ok};
      end
      for (int i = 0; i < NC; i++) begin
        if (hit(reg_addr,
            mst_pkg::MST_OFS_DUR0 + 8'(i) * mst_pkg::MST_STEP)) begin
          rdata_next = {{(32-CNT_W){1'b0}}, dur_reg[i]};
        end
        if (hit(reg_addr,
            mst_pkg::MST_OFS_MIN0 + 8'(2 * i) * mst_pkg::MST_STEP)) begin
          rdata_next = zx(min_v[i]);
        end
        if (hit(reg_addr,
            mst_pkg::MST_OFS_MIN0 + 8'(2 * i + 1) * mst_pkg::MST_STEP)) begin
          rdata_next = zx(max_v[i]);
        end
        if (hit(reg_addr,
            mst_pkg::MST_OFS_AVG0 + 8'(i) * mst_pkg::MST_STEP)) begin
          rdata_next = zx(avg_v[i]);
        end
        if (hit(reg_addr,
            mst_pkg::MST_OFS_PEAK0 + 8'(i) * mst_pkg::MST_STEP)) begin
          rdata_next = zx(peak_v[i]);
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata = rdata_reg;

  // ------------------------------------------------------------
  // min and max tracking
  // ------------------------------------------------------------
  // restart on clear or config change
  assign clr_min = trg_rise[mst_pkg::MST_TRG_MIN] || cfg_wr ||
                   (wr_cmd && reg_wdata[mst_pkg::MST_CMD_CLR_MIN]);
  assign clr_max = trg_rise[mst_pkg::MST_TRG_MAX] || cfg_wr ||
                   (wr_cmd && reg_wdata[mst_pkg::MST_CMD_CLR_MAX]);

  // ------------------------------------------------------------
  // per-quantity channels
  // ------------------------------------------------------------
  for (genvar g = 0; g < NC; g++) begin : g_ch
    mst_avg_if #(.W(W), .CNT_W(CNT_W)) link ();

    mst_minmax #(.W(W)) u_mm (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .sample_valid(meas_valid),
      .sample(samp[g]),
      .clr_min(clr_min),
      .clr_max(clr_max),
      .min_val(min_v[g]),
      .max_val(max_v[g]),
      .min_ok(min_ok[g]),
      .max_ok(max_ok[g])
    );

    assign link.sample_valid = meas_valid;
    assign link.sample = samp[g];
    assign link.sliding = ctrl_reg[mst_pkg::MST_CTRL_SLIDE0 + g];
    assign link.by_edge = ctrl_reg[mst_pkg::MST_CTRL_EDGE0 + g];
    assign link.duration = dur_reg[g];
    assign link.period_edge = trg_rise[mst_pkg::MST_TRG_PER0 + g];
    // trigger clear edge
    // a settings change restarts the window to keep it consistent
    assign link.clear = trg_rise[mst_pkg::MST_TRG_CLR0 + g] ||
                        wr_ctrl || cfg_wr_ch[g] ||
                        (wr_cmd && reg_wdata[mst_pkg::MST_CMD_CLR_AVG0 + g]);

    if (g != 0 || HAS_CURRENT_AVG) begin : g_avg
      mst_avg_chan #(
        .W(W),
        .DEPTH(DEPTH),
        .CNT_W(CNT_W),
        .HAS_PEAK(g != 1)
      ) u_avg (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .ch(link.chan)
      );
    end else begin : g_none
      assign link.avg = '0;
      assign link.peak = '0;
    end
    assign avg_v[g] = link.avg;
    assign peak_v[g] = link.peak;
  end
endmodule

// ===== verif/mst_meas_model.sv
// Purpose: measurement engine handing one sample set per request
// Assumes: go is a one-cycle request, vals stable with it
// Notes: between samples the lines flip each cycle, first the inverted last value, then the last value again
`timescale 1ns/1ps
module mst_meas_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // request and samples
  input wire logic go,
  input wire logic [47:0] vals,
  output logic meas_valid,
  output logic [15:0] meas_current,
  output logic [15:0] meas_voltage,
  output logic [15:0] meas_power
);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meas_valid <= 1'b0;
      {meas_current, meas_voltage, meas_power} <= 48'h0;
    end else begin
      meas_valid <= go;
      // outside a sample the lines flip each cycle, so stale data shows every other cycle
      {meas_current, meas_voltage, meas_power} <= go ? vals :
        ~{meas_current, meas_voltage, meas_power};
    end
  end
endmodule

// ===== verif/mst_top_checker.sv
// Purpose: port assertions for the statistics tracker
// Assumes: a write and a following read stand two cycles apart
// Notes: shadow copies of the writable settings
`timescale 1ns/1ps
module mst_top_checker #(
  parameter int W = 16,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port and samples
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic meas_valid,
  input wire logic [W-1:0] meas_current
);
  logic [5:0] ctrl_sh;
  logic [CNT_W-1:0] dur_sh[3];
  logic [CNT_W-1:0] dur_sel;
  logic [7:0] rel;
  logic is_dur;
  assign rel = reg_addr - mst_pkg::MST_OFS_DUR0;
  assign is_dur = rel < 8'h0c && rel[1:0] == 2'b00;
  // index 3 gives x, only looked at when is_dur
  assign dur_sel = dur_sh[rel[3:2]];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_sh <= mst_pkg::MST_CTRL_RST;
      dur_sh <= '{default: CNT_W'(mst_pkg::MST_DUR_RST)};
    end else if (reg_wr && reg_addr == mst_pkg::MST_OFS_CTRL) begin
      ctrl_sh <= reg_wdata[5:0];
    end else if (reg_wr && is_dur) begin
      dur_sh[rel[3:2]] <= reg_wdata[CNT_W-1:0];
    end
  end
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside a read");
  chk_ctrl_back: assert property (
    reg_rd && reg_addr == mst_pkg::MST_OFS_CTRL |=> reg_rdata == 32'(ctrl_sh))
    else $error("control readback wrong");
  chk_dur_back: assert property (
    reg_rd && is_dur |=> reg_rdata == 32'($past(dur_sel)))
    else $error("duration readback wrong");
  chk_cmd_zero: assert property (
    reg_rd && reg_addr == mst_pkg::MST_OFS_CMD |=> reg_rdata == 32'h0)
    else $error("command register not zero");
  chk_unmapped_zero: assert property (
    reg_rd && reg_addr > mst_pkg::MST_OFS_STAT |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_volt_peak: assert property (
    reg_rd && reg_addr == mst_pkg::MST_OFS_PEAK0 + 8'h04 |=> reg_rdata == 0)
    else $error("voltage peak not zero");
  chk_cfg_restart: assert property (
    reg_wr && reg_addr == mst_pkg::MST_OFS_CTRL && !meas_valid ##1 !meas_valid
    ##1 reg_rd && reg_addr == mst_pkg::MST_OFS_STAT && !meas_valid
    |=> reg_rdata == 32'h0) else $error("tracking not restarted");
  chk_first_min: assert property (
    reg_wr && reg_addr == mst_pkg::MST_OFS_CTRL && !meas_valid ##1 meas_valid
    ##1 reg_rd && reg_addr == mst_pkg::MST_OFS_MIN0
    |=> reg_rdata == 32'($past(meas_current, 2))) else $error("min not seeded");
  chk_avg_clear: assert property (
    reg_wr && reg_addr == mst_pkg::MST_OFS_CMD && reg_wdata[4:2] == 3'h7 ##2
    reg_rd && reg_addr == mst_pkg::MST_OFS_AVG0 + 8'h08 |=> reg_rdata == 0)
    else $error("average not cleared");
  cov_ctrl_wr: cover property (reg_wr && reg_addr == mst_pkg::MST_OFS_CTRL);
  cov_sample: cover property (meas_valid);
  cov_stat_rd: cover property (reg_rd && reg_addr == mst_pkg::MST_OFS_STAT);
endmodule
bind mst_top mst_top_checker #(.W(W), .CNT_W(CNT_W)) mst_top_checker_i (
  .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .meas_valid(meas_valid),
  .meas_current(meas_current));

// ===== verif/mst_top_bench.sv
// Purpose: self-checking bench for the statistics tracker
// Assumes: one sample set per 40 cycles, window store cut to 8
// Notes: reads queue expected data, a watcher compares a cycle later
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((e) !== (g)) begin \
  err_total++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module mst_top_bench;
  localparam logic [7:0] CT = mst_pkg::MST_OFS_CTRL;
  localparam logic [7:0] MN = mst_pkg::MST_OFS_MIN0;
  localparam logic [7:0] AV = mst_pkg::MST_OFS_AVG0;
  localparam logic [7:0] ST = mst_pkg::MST_OFS_STAT;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0, go = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, ev;
  logic [47:0] vals = 48'h0;
  logic meas_valid;
  logic [15:0] mc, mv, mp;
  logic [7:0] trg = 8'h00;
  logic [15:0] s[3], mn[3], mx[3], av[3], pk[3];
  logic [16:0] sm[3];
  logic [31:0] exp_q[$];
  string nm_q[$];
  string en;
  int err_total = 0, compares = 0, cyc = 0;
  always #12.5 core_clk = ~core_clk;
  mst_top #(.DEPTH(8)) mst_top_i (.core_clk(core_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_valid(meas_valid),
    .meas_current(mc), .meas_voltage(mv), .meas_power(mp),
    .min_clear_trigger(trg[0]), .max_clear_trigger(trg[1]),
    .current_avg_period_trigger(trg[2]),
    .voltage_avg_period_trigger(trg[3]),
    .power_avg_period_trigger(trg[4]), .current_avg_clear_trigger(trg[5]),
    .voltage_avg_clear_trigger(trg[6]), .power_avg_clear_trigger(trg[7]));
  mst_meas_model mst_meas_model_i (.core_clk(core_clk), .rst_b(rst_b),
    .go(go), .vals(vals), .meas_valid(meas_valid), .meas_current(mc),
    .meas_voltage(mv), .meas_power(mp));
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit g);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    go <= g;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    go <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    nm_q.push_back($sformatf("reg %h", a));
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  // samples kept 40 cycles apart, the divider needs 33
  task automatic send();
    @(posedge core_clk);
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    repeat (40) @(posedge core_clk);
  endtask
  task automatic trig(input int i, input logic l);
    @(posedge core_clk);
    trg[i] <= l;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk) begin
    if (rd_d) begin
      ev = exp_q.pop_front();
      en = nm_q.pop_front();
      `CHK(en, ev, reg_rdata)
    end
    rd_d <= reg_rd;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    ev = $urandom(32'h9f84);
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(CT, 32'h0); // own settings
    rd(CT + 8'h08, 32'(mst_pkg::MST_DUR_RST)); // duration
    rd(ST, 32'h0); // restart
    rd(8'h80, 32'h0);
    rd(CT + 8'h04, 32'h0); // command word reads zero
    $display("reset test done");
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 3; i++) begin
        s[i] = 16'($urandom);
        mn[i] = (k == 0 || s[i] < mn[i]) ? s[i] : mn[i];
        mx[i] = (k == 0 || s[i] > mx[i]) ? s[i] : mx[i];
      end
      vals <= {s[0], s[1], s[2]};
      if (k == 0) begin
        wr(CT, 32'h0, 1'b1);
        rd(MN, 32'(s[0])); // seeds min
        repeat (40) @(posedge core_clk);
      end else begin
        send();
      end
    end
    for (int i = 0; i < 3; i++) begin
      rd(MN + 8'(8 * i), 32'(mn[i])); // running min
      rd(MN + 8'(8 * i + 4), 32'(mx[i])); // running max
    end
    rd(ST, 32'h3f); // all seeded
    wr(CT + 8'h04, 32'h1, 1'b0);
    rd(ST, 32'h38); // min only
    rd(MN + 8'h04, 32'(mx[0])); // max kept
    trig(1, 1'b1);
    rd(MN + 8'h04, 32'h0); // max trigger
    rd(ST, 32'h0); // all cleared
    send();
    rd(MN + 8'h04, 32'(s[0])); // held high
    trig(0, 1'b1);
    rd(ST, 32'h38); // min trigger
    wr(CT + 8'h04, 32'h2, 1'b0);
    rd(ST, 32'h0); // max command
    trig(0, 1'b0);
    trig(1, 1'b0);
    $display("min max test done");
    for (int i = 0; i < 3; i++) wr(CT + 8'(8 + 4 * i), 32'h2, 1'b0);
    rd(CT + 8'h0c, 32'h2); // own duration
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 3; i++) begin
        s[i] = 16'($urandom);
        sm[i] = (k % 2 ? sm[i] : 17'h0) + s[i];
      end
      vals <= {s[0], s[1], s[2]};
      send();
      for (int i = 0; i < 3 && k % 2; i++) begin
        av[i] = 16'(sm[i] >> 1);
        pk[i] = (k == 1 || av[i] > pk[i]) ? av[i] : pk[i];
        rd(AV + 8'(4 * i), 32'(av[i])); // fresh period
      end
    end
    rd(AV + 8'h0c, 32'(pk[0])); // current peak
    rd(AV + 8'h14, 32'(pk[2])); // power peak
    rd(AV + 8'h10, 32'h0); // no voltage peak
    trig(5, 1'b1);
    rd(AV, 32'h0); // clear trigger
    rd(AV + 8'h0c, 32'h0); // peak too
    rd(AV + 8'h08, 32'(av[2])); // other kept
    wr(CT + 8'h04, 32'h1c, 1'b0);
    rd(AV + 8'h08, 32'h0); // command clear
    rd(AV + 8'h14, 32'h0); // peak with it
    trig(5, 1'b0);
    $display("average test done");
    wr(CT, 32'h2, 1'b0);
    rd(ST, 32'h0); // config change
    rd(CT, 32'h2); // sliding set
    for (int k = 0; k < 3; k++) begin
      s[k] = 16'($urandom);
      vals <= {16'h0, s[k], 16'h0};
      send();
      if (k > 0) rd(AV + 8'h04, 32'((17'(s[k-1]) + s[k]) >> 1));
    end
    wr(CT, 32'h10, 1'b0);
    trig(3, 1'b1);
    trig(3, 1'b0);
    for (int k = 0; k < 2; k++) begin
      s[k] = 16'($urandom);
      vals <= {16'h0, s[k], 16'h0};
      send();
    end
    rd(AV + 8'h04, 32'h0); // no early result
    trig(3, 1'b1);
    repeat (40) @(posedge core_clk);
    rd(AV + 8'h04, 32'((17'(s[0]) + s[1]) >> 1)); // edge period
    wr(CT, 32'h0, 1'b0);
    wr(CT + 8'h0c, 32'h0, 1'b0);
    send();
    rd(AV + 8'h04, 32'(s[1])); // zero duration acts as one
    $display("window test done");
    tally_and_finish();
  end
endmodule
